// ==== rtl/safety_timing_relay.sv ====
// Safety timing relay: six switching modes driven by activation, trigger and hold coils
// Operation
// - Drop of activation deactivates, opens enable
// - Trigger starts timing per selected mode
// - Hold coil freezes elapsed time
// - Fault contact closes on error
// - Time values scaled by range, ms rounded
// - On-delay closes after full time held
// - Early trigger drop aborts on-delay
// - Off-delay runs after trigger falls
// - Non-retrig off-delay partial intervals accumulate
// - Retrigger clears elapsed time
// - Combined mode: T1 on, T2 off
// - Combined: early drop, no output
// - Combined: hold suspends both delays
// - Combined: hold ignored while steady on
// - Pulse lasts exactly set time
// - Flash mark T1, space T2
// - Flash symmetry by values, hold suspends
// - Resolution 50 ms, 1 s, 1 min
// - Tolerance 50 ms, late expiry seen later
// - Diagnostic word reports state codes
// - Elapsed output shows running time
`timescale 1ns/1ps
module safety_timing_relay #(
    parameter int CYC_SEC      = timing_relay_pkg::CYC_SEC,
    parameter int CYC_MIN_SEC  = timing_relay_pkg::CYC_MIN_SEC,
    parameter int CYC_HOUR_MIN = timing_relay_pkg::CYC_HOUR_MIN
) (
    input  wire logic                          CORE_CLK_I,
    input  wire logic                          NRST_I,
    input  wire logic                          CLK_EN_I,
    input  wire logic                          SAFETY_ACTIVATE_COIL_I,
    input  wire logic                          TRIGGER_COIL_I,
    input  wire logic                          HOLD_COIL_I,
    input  wire logic [2:0]                    MODE_I,
    input  wire logic [1:0]                    RANGE_I,
    input  wire logic [timing_relay_pkg::TW-1:0] TIME_VALUE_ONE_I,
    input  wire logic [timing_relay_pkg::TW-1:0] TIME_VALUE_TWO_I,
    output logic                               ENABLE_CONTACT_O,
    output logic                               FAULT_CONTACT_O,
    output logic [timing_relay_pkg::TW-1:0]    ELAPSED_VALUE_OUT_O,
    output logic [15:0]                        DIAGNOSTIC_WORD_O
);
    import timing_relay_pkg::*;

    // ************************************************************
    // Types and signals
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE     = 6'b000001,
        ST_WAIT     = 6'b000010,
        ST_ON_RUN   = 6'b000100,
        ST_ACTIVE   = 6'b001000,
        ST_OFF_RUN  = 6'b010000,
        ST_WAIT_LOW = 6'b100000
    } state_type;

    state_type         state_reg;
    state_type         state_next;
    logic [TW-1:0]     elapsed_reg;
    logic [TW-1:0]     elapsed_next;
    logic              out_reg;
    logic              out_next;
    logic              phase_reg;
    logic              phase_next;
    logic              fault_reg;
    logic [15:0]       diag_reg;
    logic              act_s1_reg;
    logic              act_s2_reg;
    logic              trg_s1_reg;
    logic              trg_s2_reg;
    logic              hld_s1_reg;
    logic              hld_s2_reg;
    logic              trg_d_reg;
    logic              tick;
    logic              running;
    logic              step_clear;
    logic [TW-1:0]     set_one;
    logic [TW-1:0]     set_two;
    logic [TW-1:0]     target;
    logic              expired;
    logic              trg_rise;
    logic              bad_cfg;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Set time in ticks; ms values round up to a whole 50 ms step
    function automatic logic [TW-1:0] to_ticks(input logic [1:0] rng, input logic [TW-1:0] val);
        logic [TW-1:0] steps;
        steps = '0;
        if (rng == RANGE_SEC) begin
            steps = TW'((32'(val) + 32'(STEP_SEC_MS) - 32'h1) / 32'(STEP_SEC_MS));
        end else begin
            steps = val;
        end
        return steps;
    endfunction : to_ticks

    assign set_one = to_ticks(RANGE_I, TIME_VALUE_ONE_I);
    assign set_two = to_ticks(RANGE_I, TIME_VALUE_TWO_I);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Coils may come from unrelated logic, so two stages each
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            act_s1_reg <= 1'b0;
            act_s2_reg <= 1'b0;
            trg_s1_reg <= 1'b0;
            trg_s2_reg <= 1'b0;
            hld_s1_reg <= 1'b0;
            hld_s2_reg <= 1'b0;
            trg_d_reg  <= 1'b0;
        end else if (CLK_EN_I) begin
            act_s1_reg <= SAFETY_ACTIVATE_COIL_I;
            act_s2_reg <= act_s1_reg;
            trg_s1_reg <= TRIGGER_COIL_I;
            trg_s2_reg <= trg_s1_reg;
            hld_s1_reg <= HOLD_COIL_I;
            hld_s2_reg <= hld_s1_reg;
            trg_d_reg  <= trg_s2_reg;
        end
    end

    assign trg_rise = trg_s2_reg && !trg_d_reg;

    // ************************************************************
    // Time base
    // ************************************************************
    // Only timing states run the base; hold freezes it mid-step
    assign running = (state_reg == ST_ON_RUN || state_reg == ST_OFF_RUN) && !hld_s2_reg;
    // Step phase restarts outside timing states, so each run entered from a non-timing state starts on a whole step
    assign step_clear = (state_reg != ST_ON_RUN) && (state_reg != ST_OFF_RUN);

    tick_base #(
        .CYC_SEC      (CYC_SEC),
        .CYC_MIN_SEC  (CYC_MIN_SEC),
        .CYC_HOUR_MIN (CYC_HOUR_MIN)
    ) u_tick (
        .clk_i   (CORE_CLK_I),
        .nrst_i  (NRST_I),
        .ce_i    (CLK_EN_I),
        .range_i (RANGE_I),
        .run_i   (running),
        .clear_i (step_clear),
        .tick_o  (tick)
    );

    // Target of the interval now running
    always_comb begin
        target = set_one;
        if ((MODE_I == MODE_ON_OFF || MODE_I == MODE_FLASH) && state_reg == ST_OFF_RUN) begin
            target = set_two;
        end
    end

    // Expiry is seen on the cycle after the final tick lands
    assign expired = (elapsed_reg >= target);

    // Unknown mode or range, or a first time value above SEC_MAX_MS in the ms range, is an error
    assign bad_cfg = (MODE_I > MODE_FLASH) || (RANGE_I > RANGE_HOUR_MIN) ||
                     (RANGE_I == RANGE_SEC && TIME_VALUE_ONE_I > TW'(SEC_MAX_MS));

    // ************************************************************
    // Mode state machine
    // ************************************************************
    always_comb begin
        state_next   = state_reg;
        elapsed_next = elapsed_reg;
        out_next     = out_reg;
        phase_next   = phase_reg;
        if (tick) begin
            elapsed_next = elapsed_reg + TW'(1);
        end
        if (!act_s2_reg || fault_reg) begin
            state_next   = ST_IDLE;
            elapsed_next = '0;
            out_next     = 1'b0;
            phase_next   = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_next = ST_WAIT;
                end
                ST_WAIT: begin
                    elapsed_next = '0;
                    if (trg_s2_reg) begin
                        case (MODE_I)
                            MODE_OFF_DELAY, MODE_OFF_RETRIG: begin
                                state_next = ST_ACTIVE;
                                out_next   = 1'b1;
                            end
                            MODE_PULSE: begin
                                state_next = ST_OFF_RUN;
                                out_next   = 1'b1;
                            end
                            MODE_FLASH: begin
                                state_next = ST_OFF_RUN;
                                out_next   = 1'b1;
                                phase_next = 1'b0;
                            end
                            default: begin
                                state_next = ST_ON_RUN;
                            end
                        endcase
                    end
                end
                ST_ON_RUN: begin
                    if (!trg_s2_reg) begin
                        state_next   = ST_WAIT;
                        elapsed_next = '0;
                    end else if (expired) begin
                        state_next   = ST_ACTIVE;
                        out_next     = 1'b1;
                        elapsed_next = '0;
                    end
                end
                ST_ACTIVE: begin
                    // Hold coil has no bearing here: nothing is timing
                    if (!trg_s2_reg) begin
                        if (MODE_I == MODE_ON_DELAY) begin
                            state_next = ST_WAIT;
                            out_next   = 1'b0;
                        end else begin
                            state_next = ST_OFF_RUN;
                        end
                    end
                end
                ST_OFF_RUN: begin
                    if (MODE_I == MODE_FLASH) begin
                        if (!trg_s2_reg) begin
                            state_next = ST_WAIT;
                            out_next   = 1'b0;
                        end else if (elapsed_reg >= (phase_reg ? set_two : set_one)) begin
                            phase_next   = !phase_reg;
                            out_next     = phase_reg;
                            elapsed_next = '0;
                        end
                    end else if (MODE_I == MODE_PULSE) begin
                        if (expired) begin
                            out_next   = 1'b0;
                            state_next = trg_s2_reg ? ST_WAIT_LOW : ST_WAIT;
                        end
                    end else if (expired) begin
                        state_next = ST_WAIT;
                        out_next   = 1'b0;
                    end else if (trg_rise) begin
                        // Retrig clears; plain off-delay keeps the partial sum
                        if (MODE_I == MODE_OFF_RETRIG) begin
                            elapsed_next = '0;
                        end
                    end else if (trg_s2_reg) begin
                        elapsed_next = elapsed_reg;
                    end
                end
                ST_WAIT_LOW: begin
                    if (!trg_s2_reg) begin
                        state_next = ST_WAIT;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_reg   <= ST_IDLE;
            elapsed_reg <= '0;
            out_reg     <= 1'b0;
            phase_reg   <= 1'b0;
        end else if (CLK_EN_I) begin
            state_reg   <= state_next;
            elapsed_reg <= elapsed_next;
            out_reg     <= out_next;
            phase_reg   <= phase_next;
        end
    end

    // ************************************************************
    // Fault and diagnostics
    // ************************************************************
    // Fault latched while activated; cleared only by deactivation
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fault_reg <= 1'b0;
        end else if (CLK_EN_I) begin
            if (bad_cfg && act_s2_reg) begin
                fault_reg <= 1'b1;
            end else if (!act_s2_reg) begin
                fault_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            diag_reg <= DG_NO_ENABLE;
        end else if (CLK_EN_I) begin
            if (fault_reg) begin
                diag_reg <= DG_ERROR;
            end else if (state_reg == ST_IDLE) begin
                diag_reg <= DG_NO_ENABLE;
            end else if (state_reg == ST_WAIT) begin
                diag_reg <= DG_WAIT_START;
            end else if (state_reg == ST_ON_RUN || state_reg == ST_OFF_RUN) begin
                if (hld_s2_reg) begin
                    diag_reg <= out_reg ? DG_STOP_1 : DG_STOP_0;
                end else begin
                    diag_reg <= out_reg ? DG_RUN_1 : DG_RUN_0;
                end
            end else if (state_reg == ST_WAIT_LOW) begin
                diag_reg <= out_reg ? DG_WAIT_FALL_1 : DG_WAIT_FALL_0;
            end else begin
                diag_reg <= DG_ACTIVE;
            end
        end
    end

    assign ENABLE_CONTACT_O    = out_reg;
    assign FAULT_CONTACT_O     = fault_reg;
    assign ELAPSED_VALUE_OUT_O = elapsed_reg;
    assign DIAGNOSTIC_WORD_O   = diag_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);

    AST_DEACT_OPENS: assert property (CLK_EN_I && !act_s2_reg |=> !ENABLE_CONTACT_O)
        else $error("enable stayed closed after deactivation");
    AST_DEACT_CLEARS: assert property (CLK_EN_I && !act_s2_reg |=> ELAPSED_VALUE_OUT_O == '0)
        else $error("elapsed not cleared on deactivation");
    AST_HOLD_FREEZES: assert property (hld_s2_reg && state_reg == ST_ON_RUN && trg_s2_reg && act_s2_reg
                                       && !expired && !fault_reg && CLK_EN_I
                                       |=> $stable(ELAPSED_VALUE_OUT_O))
        else $error("elapsed advanced under hold");
    AST_ON_EARLY_DROP: assert property (state_reg == ST_ON_RUN && !trg_s2_reg && CLK_EN_I
                                        |=> !ENABLE_CONTACT_O && ELAPSED_VALUE_OUT_O == '0)
        else $error("on-delay closed after early drop");
    AST_ON_DROP_OPENS: assert property (MODE_I == MODE_ON_DELAY && state_reg == ST_ACTIVE && !trg_s2_reg
                                        && CLK_EN_I |=> !ENABLE_CONTACT_O)
        else $error("on-delay output not opened");
    AST_RETRIG_CLEARS: assert property (MODE_I == MODE_OFF_RETRIG && state_reg == ST_OFF_RUN && trg_rise
                                        && !expired && act_s2_reg && !fault_reg && CLK_EN_I
                                        |=> ELAPSED_VALUE_OUT_O == '0)
        else $error("retrigger did not clear elapsed");
    AST_FAULT_SETS: assert property (bad_cfg && act_s2_reg && CLK_EN_I |=> FAULT_CONTACT_O)
        else $error("fault not raised");
    AST_ACTIVE_STEADY: assert property (state_reg == ST_ACTIVE && $past(state_reg) == ST_ACTIVE
                                        |-> $stable(ELAPSED_VALUE_OUT_O))
        else $error("elapsed moved while steady on");
    AST_DIAG_WAIT: assert property (state_reg == ST_WAIT && !fault_reg && CLK_EN_I
                                    |=> DIAGNOSTIC_WORD_O == DG_WAIT_START)
        else $error("wrong diagnostic for waiting");

    COV_ON_DELAY: cover property (MODE_I == MODE_ON_DELAY && state_reg == ST_ON_RUN ##1 state_reg == ST_ACTIVE);
    COV_OFF_EXPIRE: cover property (state_reg == ST_OFF_RUN && expired && MODE_I == MODE_OFF_DELAY);
    COV_PULSE_LONG: cover property (state_reg == ST_WAIT_LOW);
    COV_FLASH_TOGGLE: cover property (MODE_I == MODE_FLASH && $fell(ENABLE_CONTACT_O) && trg_s2_reg);

endmodule : safety_timing_relay

// ==== rtl/tick_base.sv ====
// Time base: emits one tick per resolution step of the selected range
`timescale 1ns/1ps
module tick_base #(
    parameter int CYC_SEC      = 500_000,
    parameter int CYC_MIN_SEC  = 10_000_000,
    parameter int CYC_HOUR_MIN = 600_000_000
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic [1:0] range_i,
    input  wire logic       run_i,
    input  wire logic       clear_i,
    output logic            tick_o
);
    import timing_relay_pkg::*;

    logic [31:0] cnt_reg;
    logic [31:0] limit;

    // Cycles per step for the selected range
    always_comb begin
        if (range_i == RANGE_SEC) begin
            limit = 32'(CYC_SEC);
        end else if (range_i == RANGE_MIN_SEC) begin
            limit = 32'(CYC_MIN_SEC);
        end else begin
            limit = 32'(CYC_HOUR_MIN);
        end
    end

    // Counter holds while not running unless clear_i is set, so a stop resumes mid-step
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= 32'h0000_0000;
        end else if (ce_i && clear_i) begin
            cnt_reg <= 32'h0000_0000;
        end else if (ce_i && run_i) begin
            if (cnt_reg >= limit - 32'h0000_0001) begin
                cnt_reg <= 32'h0000_0000;
            end else begin
                cnt_reg <= cnt_reg + 32'h0000_0001;
            end
        end
    end

    assign tick_o = ce_i && run_i && (cnt_reg >= limit - 32'h0000_0001);

endmodule : tick_base

// ==== rtl/timing_relay_pkg.sv ====
// Package: modes, ranges, diagnostic codes and timing constants of the safety timing relay
package timing_relay_pkg;

    // Operating modes
    localparam logic [2:0] MODE_ON_DELAY    = 3'h0;
    localparam logic [2:0] MODE_OFF_DELAY   = 3'h1;
    localparam logic [2:0] MODE_ON_OFF      = 3'h2;
    localparam logic [2:0] MODE_OFF_RETRIG  = 3'h3;
    localparam logic [2:0] MODE_PULSE       = 3'h4;
    localparam logic [2:0] MODE_FLASH       = 3'h5;

    // Time ranges
    localparam logic [1:0] RANGE_SEC        = 2'h0;
    localparam logic [1:0] RANGE_MIN_SEC    = 2'h1;
    localparam logic [1:0] RANGE_HOUR_MIN   = 2'h2;

    // Clock and resolution figures
    localparam int CLK_HZ                   = 10_000_000;
    localparam int STEP_SEC_MS              = 50;
    localparam int STEP_MIN_SEC_S           = 1;
    localparam int STEP_HOUR_MIN_MIN        = 1;
    localparam int CYC_SEC                  = CLK_HZ / 1000 * STEP_SEC_MS;
    localparam int CYC_MIN_SEC              = CLK_HZ * STEP_MIN_SEC_S;
    localparam int CYC_HOUR_MIN             = CLK_HZ * 60 * STEP_HOUR_MIN_MIN;
    localparam int SEC_MAX_MS               = 999_950;

    // Time value width (ms up to 999950, or seconds/minutes up to 5999)
    localparam int TW                       = 20;

    // Diagnostic codes
    localparam logic [15:0] DG_NO_ENABLE    = 16'h0000;
    localparam logic [15:0] DG_WAIT_START   = 16'h2001;
    localparam logic [15:0] DG_WAIT_FALL_0  = 16'h200B;
    localparam logic [15:0] DG_RUN_0        = 16'h200C;
    localparam logic [15:0] DG_STOP_0       = 16'h200D;
    localparam logic [15:0] DG_ACTIVE       = 16'h800C;
    localparam logic [15:0] DG_WAIT_FALL_1  = 16'h800D;
    localparam logic [15:0] DG_RUN_1        = 16'h800E;
    localparam logic [15:0] DG_STOP_1       = 16'h800F;
    localparam logic [15:0] DG_ERROR        = 16'hF001;

endpackage : timing_relay_pkg

// ==== test/coil_source.sv ====
// Far-side model: the logic blocks that drive the relay's three coils
`timescale 1ns/1ps
module coil_source (
    input  wire logic clk_i,
    output logic      act_o,
    output logic      trig_o,
    output logic      hold_o
);
    // All coils start dropped out
    initial begin
        act_o  = 1'b0;
        trig_o = 1'b0;
        hold_o = 1'b0;
    end

    // Coils move only at the falling edge, well clear of the sampling edge
    task automatic drive(input logic a, input logic t, input logic h);
        @(negedge clk_i);
        act_o  = a;
        trig_o = t;
        hold_o = h;
    endtask : drive
endmodule : coil_source

// ==== test/testbench.sv ====
// Self-checking bench for the safety timing relay
`timescale 1ns/1ps
module testbench;
    import timing_relay_pkg::*;
    // Short tick periods keep the run brief; windows scale with them
    localparam int CS = 16;
    typedef struct {logic v; int lo; int hi;} note_type;
    logic          clk;
    logic          nrst;
    logic [2:0]    mode;
    logic [1:0]    rng;
    logic [TW-1:0] t1;
    logic [TW-1:0] t2;
    logic [TW-1:0] snap;
    logic [TW-1:0] elap;
    logic [15:0]   diag;
    logic          en;
    logic          en_prev;
    logic          flt;
    logic          ce;
    logic          act;
    logic          trg;
    logic          hld;
    note_type      notes[$];
    note_type      n;
    int            fail_count = 0;
    int            compares = 0;
    int            cyc = 0;
    int            base = 0;
    int            seed = 32'h2b7a;
    int            tk;

    safety_timing_relay #(.CYC_SEC(CS), .CYC_MIN_SEC(2 * CS), .CYC_HOUR_MIN(4 * CS)) i_safety_timing_relay (
        .CORE_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(ce), .SAFETY_ACTIVATE_COIL_I(act),
        .TRIGGER_COIL_I(trg), .HOLD_COIL_I(hld), .MODE_I(mode), .RANGE_I(rng),
        .TIME_VALUE_ONE_I(t1), .TIME_VALUE_TWO_I(t2), .ENABLE_CONTACT_O(en),
        .FAULT_CONTACT_O(flt), .ELAPSED_VALUE_OUT_O(elap), .DIAGNOSTIC_WORD_O(diag));
    coil_source i_coil_source (.clk_i(clk), .act_o(act), .trig_o(trg), .hold_o(hld));

    // ************
    // Helpers
    // ************
    task automatic fail(input string m);
        fail_count++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask : fail
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) fail(m);
    endtask : chk
    task automatic idle(input int k);
        repeat (k) @(negedge clk);
    endtask : idle
    // A note's window counts from the stimulus, or from the previous change
    task automatic expect_en(input logic v, input int lo, input int hi);
        if (notes.size() == 0) base = cyc;
        notes.push_back('{v, lo, hi});
    endtask : expect_en
    task automatic drained;
        chk(notes.size() == 0, "expected enable change missing");
        notes.delete();
    endtask : drained
    // Drop activation, check the cleared state, load config, reactivate
    task automatic setup(input logic [2:0] m, input logic [1:0] r, input int a, input int b);
        i_coil_source.drive(1'b0, 1'b0, 1'b0);
        idle(6);
        chk(en === 1'b0 && elap === '0 && diag === DG_NO_ENABLE, "not cleared on deactivation");
        mode = m;
        rng  = r;
        t1   = TW'(a);
        t2   = TW'(b);
        i_coil_source.drive(1'b1, 1'b0, 1'b0);
        idle(6);
    endtask : setup
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Each enable change takes the oldest note; sampled at the falling edge, where outputs are settled
    always @(negedge clk) begin
        cyc <= cyc + 1;
        if (nrst === 1'b1 && en !== en_prev) begin
            if (notes.size() == 0) begin
                fail("unexpected enable change");
            end else begin
                n = notes.pop_front();
                chk(en === n.v && cyc - base >= n.lo && cyc - base <= n.hi, "enable change wrong or mistimed");
                base = cyc;
            end
        end
        en_prev <= en;
    end

    // Watchdog, far beyond the expected few thousand cycles
    initial begin
        #2_000_000;
        fail("timeout");
        finish_test();
    end

    // ************
    // Scenarios
    // ************
    initial begin
        nrst = 1'b0;
        en_prev = 1'b0;
        ce = 1'b1;
        mode = MODE_ON_DELAY;
        rng = RANGE_SEC;
        t1 = '0;
        t2 = '0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        // On-delay with a random ms value, rounded up to whole steps
        tk = 1 + {$random(seed)} % 300;
        setup(MODE_ON_DELAY, RANGE_SEC, tk, 0);
        chk(diag === DG_WAIT_START, "diag waiting");
        tk = (tk + 49) / 50;
        i_coil_source.drive(1'b1, 1'b1, 1'b0);
        ce = 1'b0; // Enable low must push the whole run back by 20 cycles
        expect_en(1'b1, tk * CS + 20, tk * CS + 28);
        idle(20);
        ce = 1'b1;
        idle(tk * CS + 12);
        chk(diag === DG_ACTIVE, "diag active");
        i_coil_source.drive(1'b1, 1'b0, 1'b0);
        expect_en(1'b0, 1, 6);
        idle(8);
        drained();
        // Early drop, then a held run resuming where it stopped
        setup(MODE_ON_DELAY, RANGE_SEC, 200, 0);
        i_coil_source.drive(1'b1, 1'b1, 1'b0);
        idle(30);
        chk(diag === DG_RUN_0, "diag running");
        i_coil_source.drive(1'b1, 1'b0, 1'b0);
        idle(90);
        drained();
        i_coil_source.drive(1'b1, 1'b1, 1'b0);
        expect_en(1'b1, 118, 134);
        idle(30);
        i_coil_source.drive(1'b1, 1'b1, 1'b1);
        idle(8);
        snap = elap;
        chk(elap !== '0 && diag === DG_STOP_0, "held state");
        idle(50);
        chk(elap === snap, "elapsed moved while held");
        i_coil_source.drive(1'b1, 1'b1, 1'b0);
        idle(80);
        drained();
        i_coil_source.drive(1'b0, 1'b1, 1'b0);
        expect_en(1'b0, 1, 6);
        idle(8);
        // Off-delay, plain then retriggerable, with a mid-run re-trigger
        for (int i = 0; i < 2; i++) begin
            setup(i ? MODE_OFF_RETRIG : MODE_OFF_DELAY, RANGE_SEC, 200, 0);
            i_coil_source.drive(1'b1, 1'b1, 1'b0);
            expect_en(1'b1, 1, 6);
            idle(8);
            i_coil_source.drive(1'b1, 1'b0, 1'b0);
            idle(32);
            chk(diag === DG_RUN_1, "diag running active");
            i_coil_source.drive(1'b1, 1'b1, 1'b0);
            idle(20);
            i_coil_source.drive(1'b1, 1'b0, 1'b0);
            expect_en(1'b0, i ? 62 : 24, i ? 74 : 56);
            idle(80);
            drained();
        end
        // Combined on and off delay
        setup(MODE_ON_OFF, RANGE_SEC, 100, 150);
        i_coil_source.drive(1'b1, 1'b1, 1'b0);
        idle(10);
        i_coil_source.drive(1'b1, 1'b0, 1'b0);
        idle(60);
        drained();
        i_coil_source.drive(1'b1, 1'b1, 1'b0);
        expect_en(1'b1, 32, 40);
        idle(44);
        i_coil_source.drive(1'b1, 1'b1, 1'b1);
        idle(30);
        chk(diag === DG_ACTIVE, "hold acted while steady on");
        i_coil_source.drive(1'b1, 1'b0, 1'b1);
        idle(40);
        chk(en === 1'b1 && diag === DG_STOP_1, "off-delay not held");
        i_coil_source.drive(1'b1, 1'b0, 1'b0);
        expect_en(1'b0, 46, 58);
        idle(64);
        drained();
        // Single pulse, short and long trigger
        setup(MODE_PULSE, RANGE_SEC, 150, 0);
        for (int i = 0; i < 2; i++) begin
            i_coil_source.drive(1'b1, 1'b1, 1'b0);
            expect_en(1'b1, 1, 6);
            expect_en(1'b0, 46, 54);
            idle(i ? 120 : 8);
            chk(diag === (i ? DG_WAIT_FALL_0 : DG_RUN_1), "diag during pulse");
            i_coil_source.drive(1'b1, 1'b0, 1'b0);
            idle(i ? 8 : 70);
            drained();
        end
        // Asymmetric flashing, then hold in the space phase
        setup(MODE_FLASH, RANGE_SEC, 100, 50);
        i_coil_source.drive(1'b1, 1'b1, 1'b0);
        expect_en(1'b1, 1, 6);
        expect_en(1'b0, 30, 36);
        expect_en(1'b1, 14, 20);
        expect_en(1'b0, 30, 36);
        idle(86);
        i_coil_source.drive(1'b1, 1'b1, 1'b1);
        idle(40);
        chk(diag === DG_STOP_0, "flash not held");
        i_coil_source.drive(1'b1, 1'b0, 1'b0);
        idle(30);
        drained();
        // Minute and hour ranges give the same cycle count here
        for (int i = 1; i < 3; i++) begin
            setup(MODE_ON_DELAY, 2'(i), 3 - i, 0);
            i_coil_source.drive(1'b1, 1'b1, 1'b0);
            expect_en(1'b1, 64, 72);
            idle(76);
            i_coil_source.drive(1'b1, 1'b0, 1'b0);
            expect_en(1'b0, 1, 6);
            idle(8);
            drained();
        end
        // Bad mode and bad range raise the fault and keep enable open
        for (int i = 0; i < 2; i++) begin
            setup(i ? MODE_ON_DELAY : 3'h6, i ? 2'h3 : RANGE_SEC, 100, 0);
            chk(flt === 1'b1 && diag === DG_ERROR, "fault not raised");
            i_coil_source.drive(1'b1, 1'b1, 1'b0);
            idle(50);
            drained();
        end
        i_coil_source.drive(1'b0, 1'b0, 1'b0);
        idle(6);
        chk(flt === 1'b0, "fault kept after deactivation");
        finish_test();
    end
endmodule : testbench
